// ===== hw/adcpc_pkg.sv
// Constants and types of the converter interface configuration block
package adcpc_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_RESULT = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_SHOWN  = 4'h8;

  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

  // Status field positions
  localparam int ST_BUSY      = 0;
  localparam int ST_SHIFTING  = 1;
  localparam int ST_SERIAL    = 2;
  localparam int ST_EXTCLK    = 3;
  localparam int ST_READMODE  = 4;
  localparam int ST_MODE_LO   = 5;
  localparam int ST_ACC_LOST  = 7;
  localparam int ST_FORMAT    = 8;

  // Timing
  localparam int REF_CLK_MHZ     = 100;
  localparam int CONV_WARP_NS    = 1000;
  localparam int CONV_NORMAL_NS  = 1250;
  localparam int CONV_REDUCED_NS = 1500;
  localparam int CONV_WARP_CYC    = (CONV_WARP_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int CONV_NORMAL_CYC  = (CONV_NORMAL_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int CONV_REDUCED_CYC = (CONV_REDUCED_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int WARP_GAP_MS      = 1;
  localparam int WARP_GAP_CYC     = WARP_GAP_MS * REF_CLK_MHZ * 1000;
  localparam int SCLK_MIN_NS      = 40;
  localparam int SCLK_HALF_CYC    = (SCLK_MIN_NS * REF_CLK_MHZ + 1999) / 2000;
  localparam int RESULT_BITS      = 16;

  // Conversion speed and power modes
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_WARP,
    MODE_REDUCED
  } adcpc_mode_t;

  // Static straps
  typedef struct packed {
    logic outputFormatSelect;
    logic fastestSelect;
    logic lowPowerSelect;
    logic portTypeSelect;
  } adcpc_strap_t;

  // Serial configuration taken from data pins 7..4
  typedef struct packed {
    logic readModeOrChainInput;
    logic clockInversionSelect;
    logic markerPolaritySelect;
    logic clockSourceSelect;
  } adcpc_sercfg_t;

endpackage

// ===== hw/adcpc_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/10ps
`default_nettype none
module adcpc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule
`default_nettype wire

// ===== hw/adcpc_shifter.sv
// Result shift register, most significant bit first
`timescale 1ns/10ps
`default_nettype none
module adcpc_shifter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        load,
  input  wire logic        step,
  input  wire logic [15:0] word,
  // Serial side
  output logic             bitOut,
  output logic             active,
  output logic             finished
);

  logic [14:0] rest;
  logic [4:0]  left;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rest     <= '0;
      left     <= '0;
      bitOut   <= 1'b0;
      active   <= 1'b0;
      finished <= 1'b0;
    end else begin
      finished <= 1'b0;
      if (load) begin
        bitOut <= word[15];
        rest   <= word[14:0];
        left   <= 5'(adcpc_pkg::RESULT_BITS);
        active <= 1'b1;
      end else if (active && step) begin
        if (left == 5'h01) begin
          active   <= 1'b0;
          finished <= 1'b1;
        end else begin
          bitOut <= rest[14];
          rest   <= {rest[13:0], 1'b0};
          left   <= left - 5'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/adcpc_top.sv
// Converter digital interface configuration with register slave
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Function
// RL1 - Output format high gives straight binary, low inverts the MSB.
// RL2 - Fastest select high with low-power low selects the warp mode.
// RL3 - In warp mode the host starts conversions at most 1 ms apart.
// RL4 - With fastest select low accuracy holds for any conversion spacing.
// RL5 - Low-power high with fastest low selects the reduced power mode.
// RL6 - Port select low enables the parallel port, high the serial port.
// RL7 - Data pins 0 to 3 always output result bits 0 to 3.
// RL8 - Data pins 4 to 6 output bits in parallel, become inputs in serial.
// RL9 - Serial mode with clock source low drives the internal clock out.
// RL10 - Clock source high shifts data on the host supplied serial clock.
// RL11 - The frame marker is active high when polarity is low, else low.
// RL12 - Clock inversion flips the serial clock in both serial modes.
// RL13 - External clock updates data on rising edge, falling if inverted.
// RL14 - Read mode high outputs during conversion, low only after it. The external clock path always outputs only after conversion.
// RL15 - The serial output sends the 16-bit result MSB first.
// RL16 - The host keeps mode and port inputs stable during conversions.
// RL17 - Both selects low gives the normal full accuracy mode.
module adcpc_top #(
  parameter int unsigned WARP_GAP_CYCLES = adcpc_pkg::WARP_GAP_CYC
) (
  // Clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        linkClk,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Straps
  input  wire logic        outputFormatSelect,
  input  wire logic        fastestSelect,
  input  wire logic        lowPowerSelect,
  input  wire logic        portTypeSelect,
  // Data bus pins
  input  wire logic [15:0] dataIn,
  output logic      [15:0] dataOut,
  output logic      [15:0] dataOe,
  // Frame marker and core power
  output logic             markerOut,
  output logic             coreActive
);

  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } adcpc_conv_t;

  function automatic adcpc_pkg::adcpc_mode_t decodeMode(
    input adcpc_pkg::adcpc_strap_t s
  );
    if (s.fastestSelect && !s.lowPowerSelect)
      return adcpc_pkg::MODE_WARP; // RL2
    else if (s.lowPowerSelect && !s.fastestSelect)
      return adcpc_pkg::MODE_REDUCED; // RL5
    else
      return adcpc_pkg::MODE_NORMAL; // RL17
  endfunction

  function automatic logic [15:0] formatResult(input logic [15:0] raw,
                                               input logic ob);
    return {raw[15] ^ ~ob, raw[14:0]}; // RL1
  endfunction

  function automatic logic [7:0] convCycles(input adcpc_pkg::adcpc_mode_t m);
    case (m)
      adcpc_pkg::MODE_WARP:    return 8'(adcpc_pkg::CONV_WARP_CYC);
      adcpc_pkg::MODE_REDUCED: return 8'(adcpc_pkg::CONV_REDUCED_CYC);
      default:                 return 8'(adcpc_pkg::CONV_NORMAL_CYC);
    endcase
  endfunction

  logic [3:0]               strapVec;
  logic [3:0]               cfgVec;
  adcpc_pkg::adcpc_strap_t  strap;
  adcpc_pkg::adcpc_sercfg_t cfg;
  adcpc_pkg::adcpc_mode_t   mode;
  adcpc_conv_t              state;
  logic        serialMode;
  logic        extClock;
  logic        masterMode;
  logic        regWrite;
  logic        regRead;
  logic        convStart;
  logic        convDone;
  logic [7:0]  convCount;
  logic [15:0] pendingRaw;
  logic [15:0] shown;
  logic [15:0] next_shown;
  logic [15:0] parallelWord;
  logic [16:0] gapCount;
  logic        accuracyLost;
  logic        masterLoad;
  logic        masterStep;
  logic        masterBit;
  logic        masterActive;
  logic [1:0]  divCount;
  logic        sclkInt;
  logic [15:0] holdWord;
  logic        loadToggle;
  logic        extBusy;
  logic        doneSync;
  logic        doneSeen;
  logic [15:0] pinReg;
  logic        shiftClk;
  logic        loadSync;
  logic        loadSeen;
  logic        linkLoad;
  logic        linkBit;
  logic        linkActive;
  logic        linkFinished;
  logic        doneToggle;
  logic [3:0]  strapSyncd;
  logic [31:0] regData;
  logic [15:0] pinOe;
  logic        linkBitSync;

  // Straps and serial configuration pins pass two flops
  assign strapVec = {outputFormatSelect, fastestSelect, lowPowerSelect,
                     portTypeSelect};

  adcpc_sync #(.W(4)) strapSync (
    .clk  (ref_clk),
    .nrst (nrst),
    .din  (strapVec),
    .dout (strapSyncd)
  );

  assign strap = adcpc_pkg::adcpc_strap_t'(strapSyncd);

  // Pins 7..4 carry the serial setup while they are inputs
  adcpc_sync #(.W(4)) cfgSync (
    .clk  (ref_clk),
    .nrst (nrst),
    .din  (dataIn[7:4]),
    .dout (cfgVec)
  );

  assign cfg        = adcpc_pkg::adcpc_sercfg_t'(cfgVec);
  assign mode       = decodeMode(strap);
  assign serialMode = strap.portTypeSelect; // RL6
  assign extClock   = serialMode && cfg.clockSourceSelect; // RL10
  assign masterMode = serialMode && !cfg.clockSourceSelect; // RL9

  // Bus handshake: one wait state, answer at the second edge
  assign regWrite = write && !waitrequest;
  assign regRead  = read && waitrequest;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  // Read data selection
  always_comb begin
    regData = adcpc_pkg::READ_ZERO;
    case (address)
      adcpc_pkg::OFS_RESULT: begin
        regData[15:0] = pendingRaw;
      end
      adcpc_pkg::OFS_STATUS: begin
        regData[adcpc_pkg::ST_BUSY]       = (state == CONV_RUN);
        regData[adcpc_pkg::ST_SHIFTING]   = masterActive || extBusy;
        regData[adcpc_pkg::ST_SERIAL]     = serialMode;
        regData[adcpc_pkg::ST_EXTCLK]     = extClock;
        regData[adcpc_pkg::ST_READMODE]   = cfg.readModeOrChainInput;
        regData[adcpc_pkg::ST_MODE_LO+:2] = mode;
        regData[adcpc_pkg::ST_ACC_LOST]   = accuracyLost;
        regData[adcpc_pkg::ST_FORMAT]     = strap.outputFormatSelect;
      end
      adcpc_pkg::OFS_SHOWN: begin
        regData[15:0] = shown;
      end
      default: begin
        regData = adcpc_pkg::READ_ZERO;
      end
    endcase
  end

  // Read data is captured at the edge that lowers waitrequest
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= adcpc_pkg::READ_ZERO;
    end else if (regRead) begin
      readdata <= regData;
    end
  end

  // Conversion sequencing; writes while busy are ignored
  assign convStart = regWrite && (address == adcpc_pkg::OFS_RESULT) &&
                     (state == CONV_IDLE);
  assign convDone  = (state == CONV_RUN) && (convCount == 8'h01);
  assign next_shown = formatResult(pendingRaw, strap.outputFormatSelect); // RL1

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= CONV_IDLE;
      convCount  <= 8'h00;
      pendingRaw <= adcpc_pkg::RESULT_RESET;
    end else begin
      case (state)
        CONV_IDLE: begin
          if (convStart) begin
            state      <= CONV_RUN;
            convCount  <= convCycles(mode); // RL2 RL5 RL17
            pendingRaw <= writedata[15:0];
          end
        end
        CONV_RUN: begin
          if (convCount == 8'h01) begin
            state <= CONV_IDLE;
          end else begin
            convCount <= convCount - 8'h01;
          end
        end
        default: begin
          state <= CONV_IDLE;
        end
      endcase
    end
  end

  // Latest finished result
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shown <= adcpc_pkg::RESULT_RESET;
    end else if (convDone) begin
      shown <= next_shown;
    end
  end

  // Spacing between conversion starts, saturating at the limit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gapCount <= 17'h00000;
    end else if (convStart) begin
      gapCount <= 17'h00000;
    end else if (gapCount != 17'(WARP_GAP_CYCLES)) begin
      gapCount <= gapCount + 17'h00001;
    end
  end

  // Start spacing reaching the limit in warp mode flags lost accuracy; the set wins a tie
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      accuracyLost <= 1'b0;
    end else if (mode == adcpc_pkg::MODE_WARP &&
                 gapCount == 17'(WARP_GAP_CYCLES)) begin
      accuracyLost <= 1'b1; // RL3
    end else if (convStart) begin
      accuracyLost <= 1'b0; // RL4
    end
  end

  // Internal serial clock: read during or after conversion
  assign masterLoad = masterMode && !masterActive &&
                      (cfg.readModeOrChainInput ? convStart : convDone); // RL14
  assign masterStep = sclkInt &&
                      (divCount == 2'(adcpc_pkg::SCLK_HALF_CYC - 1));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      divCount <= 2'h0;
      sclkInt  <= 1'b0;
    end else if (!masterActive || masterLoad) begin
      divCount <= 2'h0;
      sclkInt  <= 1'b0;
    end else if (divCount == 2'(adcpc_pkg::SCLK_HALF_CYC - 1)) begin
      divCount <= 2'h0;
      sclkInt  <= ~sclkInt;
    end else begin
      divCount <= divCount + 2'h1;
    end
  end

  // Bits change on the falling internal clock, read on the rising one
  adcpc_shifter masterShift (
    .clk      (ref_clk),
    .nrst     (nrst),
    .load     (masterLoad),
    .step     (masterStep),
    .word     (cfg.readModeOrChainInput ? shown : next_shown),
    .bitOut   (masterBit),
    .active   (masterActive),
    .finished ()
  );

  // External clock: hand the word over by toggle, wait for the return
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      holdWord   <= adcpc_pkg::RESULT_RESET;
      loadToggle <= 1'b0;
      extBusy    <= 1'b0;
      doneSeen   <= 1'b0;
    end else begin
      doneSeen <= doneSync;
      if (extClock && convDone && !extBusy) begin
        holdWord   <= next_shown;
        loadToggle <= ~loadToggle;
        extBusy    <= 1'b1;
      end else if (doneSync != doneSeen) begin
        extBusy <= 1'b0;
      end
    end
  end

  // Link side; the clock sense is a static serial configuration pin
  assign shiftClk = linkClk ^ cfg.clockInversionSelect; // RL12 RL13

  adcpc_sync #(.W(1)) loadCross (
    .clk  (shiftClk),
    .nrst (nrst),
    .din  (loadToggle),
    .dout (loadSync)
  );

  always_ff @(posedge shiftClk or negedge nrst) begin
    if (!nrst) begin
      loadSeen <= 1'b0;
    end else begin
      loadSeen <= loadSync;
    end
  end

  assign linkLoad = loadSync ^ loadSeen;

  adcpc_shifter linkShift (
    .clk      (shiftClk),
    .nrst     (nrst),
    .load     (linkLoad),
    .step     (1'b1),
    .word     (holdWord),
    .bitOut   (linkBit),
    .active   (linkActive),
    .finished (linkFinished)
  ); // RL10 RL15

  always_ff @(posedge shiftClk or negedge nrst) begin
    if (!nrst) begin
      doneToggle <= 1'b0;
    end else if (linkFinished) begin
      doneToggle <= ~doneToggle;
    end
  end

  adcpc_sync #(.W(1)) doneCross (
    .clk  (ref_clk),
    .nrst (nrst),
    .din  (doneToggle),
    .dout (doneSync)
  );

  adcpc_sync #(.W(1)) bitCross (
    .clk  (ref_clk),
    .nrst (nrst),
    .din  (linkBit),
    .dout (linkBitSync)
  );

  // Pin word and drive enables
  assign parallelWord = shown;

  always_comb begin
    pinReg = parallelWord; // RL6 RL7
    pinOe  = 16'hFFFF;
    if (serialMode) begin
      pinReg[7:4] = 4'h0;
      pinOe[7:4]  = 4'h0; // RL8
      pinReg[8]   = extClock ? linkBitSync : masterBit; // RL15
      pinReg[9]   = sclkInt ^ cfg.clockInversionSelect; // RL9 RL12
      pinOe[9]    = !extClock; // RL9 RL10
    end
  end

  // Registered pin outputs, frame marker and core power
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataOut    <= 16'h0000;
      dataOe     <= 16'h000F;
      markerOut  <= 1'b0;
      coreActive <= 1'b1;
    end else begin
      dataOut    <= pinReg;
      dataOe     <= pinOe;
      markerOut  <= serialMode && ((masterActive || extBusy) ^
                                   cfg.markerPolaritySelect); // RL11
      coreActive <= (mode != adcpc_pkg::MODE_REDUCED) ||
                    (state == CONV_RUN); // RL5
    end
  end

endmodule
`default_nettype wire

// ===== bench/adcpc_top_properties.sv
// Pin direction checks for the converter interface block
`timescale 1ns/10ps
`default_nettype none
module adcpc_top_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Observed pins
  input wire logic        portTypeSelect,
  input wire logic [15:0] dataIn,
  input wire logic [15:0] dataOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_low_pins_out: assert property (dataOe[3:0] == 4'hF)
    else $error("low data pins not driven");
  a_par_pins_out: assert property (!portTypeSelect [*4] |->
    dataOe[6:4] == 3'h7) else $error("pins 4 to 6 not out");
  a_ser_pins_in: assert property (portTypeSelect [*4] |->
    dataOe[6:4] == 3'h0) else $error("pins 4 to 6 not in");
  a_par_bus_out: assert property (!portTypeSelect [*4] |->
    dataOe == 16'hFFFF) else $error("parallel bus not out");
  a_ser_cfg_in: assert property (portTypeSelect [*4] |->
    !dataOe[7]) else $error("pin 7 driven in serial");
  a_ser_data_out: assert property (portTypeSelect [*4] |->
    dataOe[8]) else $error("serial data pin not out");
  a_int_clk_out: assert property ((portTypeSelect && !dataIn[4]) [*4]
    |-> dataOe[9]) else $error("internal clock not out");
  a_ext_clk_in: assert property ((portTypeSelect && dataIn[4]) [*4]
    |-> !dataOe[9]) else $error("external clock pin driven");
endmodule
bind adcpc_top adcpc_top_properties u_props (
  .ref_clk       (ref_clk),
  .nrst          (nrst),
  .portTypeSelect(portTypeSelect),
  .dataIn        (dataIn),
  .dataOe        (dataOe)
);
`default_nettype wire

// ===== bench/adcpc_host_model.sv
// Host side model driving the shared data pins
`timescale 1ns/10ps
`default_nettype none
module adcpc_host_model (
  // Device pin state
  input  wire logic                     serial,
  input  wire adcpc_pkg::adcpc_sercfg_t cfg,
  input  wire logic [15:0]              dOut,
  input  wire logic [15:0]              dOe,
  // Pin levels
  output logic      [15:0]              pins
);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pins[i] = dOe[i] ? dOut[i] : ~dOut[i];
      if (serial && !dOe[i] && i >= 4 && i < 8) begin
        pins[i] = cfg[i-4];
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the converter interface block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                     ref_clk = 1'b0;
  logic                     linkClk = 1'b0;
  logic                     nrst = 1'b0;
  logic [3:0]               address = 4'h0;
  logic                     read = 1'b0;
  logic                     write = 1'b0;
  logic [31:0]              writedata = 32'h0;
  logic [31:0]              readdata;
  logic                     waitrequest;
  adcpc_pkg::adcpc_strap_t  st = '0;
  adcpc_pkg::adcpc_sercfg_t cfg = '0;
  logic [15:0]              pins;
  logic [15:0]              dOut;
  logic [15:0]              dOe;
  logic [31:0]              rd;
  logic [1:0]               md;
  logic                     marker;
  logic                     coreOn;
  logic [15:0]              expW;
  int                       bad_count = 0;
  int                       num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  initial #1.7 forever #3 linkClk = ~linkClk;
  adcpc_top #(.WARP_GAP_CYCLES(1000)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .linkClk(linkClk),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest),
    .outputFormatSelect(st.outputFormatSelect),
    .fastestSelect(st.fastestSelect),
    .lowPowerSelect(st.lowPowerSelect),
    .portTypeSelect(st.portTypeSelect),
    .dataIn(pins), .dataOut(dOut), .dataOe(dOe),
    .markerOut(marker), .coreActive(coreOn));
  adcpc_host_model host (.serial(st.portTypeSelect), .cfg(cfg),
    .dOut(dOut), .dOe(dOe), .pins(pins));
  task automatic end_sim;
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    d = readdata;
    read <= 1'b0;
    if (n >= 100) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic wrreg(input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    write <= 1'b0;
    if (n >= 100) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic wait_idle;
    int n = 0;
    logic [31:0] s;
    do begin
      rdreg(adcpc_pkg::OFS_STATUS, s);
      n++;
    end while ((s[adcpc_pkg::ST_BUSY] !== 1'b0 ||
                s[adcpc_pkg::ST_SHIFTING] !== 1'b0) && n < 200);
    if (n >= 200) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic capture(input logic inv, input logic pol);
    int nb = 0;
    logic prev = 1'b0;
    logic [15:0] w = 16'h0000;
    for (int c = 0; c < 400; c++) begin
      @(posedge ref_clk);
      if ((dOut[9] ^ inv) && !prev && (marker ^ pol)) begin
        w = {w[14:0], dOut[8]};
        nb++;
      end
      prev = dOut[9] ^ inv;
    end
    chk(32'(nb), 32'd16);
    chk(32'(w), 32'h0000C3A5);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      st <= adcpc_pkg::adcpc_strap_t'(4'(m));
      cfg <= adcpc_pkg::adcpc_sercfg_t'(4'(m >> 1));
      repeat (6) @(posedge ref_clk);
      rdreg(adcpc_pkg::OFS_STATUS, rd);
      md = (st.fastestSelect && !st.lowPowerSelect) ? adcpc_pkg::MODE_WARP :
           (st.lowPowerSelect && !st.fastestSelect) ? adcpc_pkg::MODE_REDUCED :
           adcpc_pkg::MODE_NORMAL;
      chk(32'(coreOn), 32'(md != adcpc_pkg::MODE_REDUCED));
      chk(32'(rd[adcpc_pkg::ST_MODE_LO+:2]), 32'(md));
      chk(32'(rd[adcpc_pkg::ST_SERIAL]), 32'(st.portTypeSelect));
      chk(32'(rd[adcpc_pkg::ST_FORMAT]), 32'(st.outputFormatSelect));
      chk(32'(dOe[3:0]), 32'h0000000F);
      chk(32'(dOe[6:4]), st.portTypeSelect ? 32'h0 : 32'h7);
      if (st.portTypeSelect) chk(32'(dOe[9]), 32'(!m[1]));
    end
    for (int f = 0; f < 2; f++) begin
      st <= adcpc_pkg::adcpc_strap_t'({f[0], 3'b000});
      cfg <= '0;
      repeat (6) @(posedge ref_clk);
      wrreg(adcpc_pkg::OFS_RESULT, 32'h0000_8A5C);
      wait_idle();
      expW = f[0] ? 16'h8A5C : 16'h0A5C;
      rdreg(adcpc_pkg::OFS_SHOWN, rd);
      chk(rd, {16'h0000, expW});
      chk(32'(dOut), 32'(expW));
    end
    for (int v = 0; v < 2; v++) begin
      st <= adcpc_pkg::adcpc_strap_t'(4'h9);
      cfg <= adcpc_pkg::adcpc_sercfg_t'({1'b0, v[0], v[0], 1'b0});
      repeat (12) @(posedge ref_clk);
      wrreg(adcpc_pkg::OFS_RESULT, 32'h0000_C3A5);
      capture(v[0], v[0]);
    end
    cfg <= adcpc_pkg::adcpc_sercfg_t'(4'h1);
    repeat (12) @(posedge ref_clk);
    wrreg(adcpc_pkg::OFS_RESULT, 32'h0000_1111);
    wait_idle();
    chk(32'(dOe[9]), 32'h0);
    st <= adcpc_pkg::adcpc_strap_t'(4'h4);
    cfg <= '0;
    repeat (6) @(posedge ref_clk);
    wrreg(adcpc_pkg::OFS_RESULT, 32'h0000_0001);
    repeat (1100) @(posedge ref_clk);
    rdreg(adcpc_pkg::OFS_STATUS, rd);
    chk(32'(rd[adcpc_pkg::ST_ACC_LOST]), 32'h1);
    st <= adcpc_pkg::adcpc_strap_t'(4'h0);
    repeat (6) @(posedge ref_clk);
    wrreg(adcpc_pkg::OFS_RESULT, 32'h0000_0001);
    repeat (1100) @(posedge ref_clk);
    rdreg(adcpc_pkg::OFS_STATUS, rd);
    chk(32'(rd[adcpc_pkg::ST_ACC_LOST]), 32'h0);
    rdreg(4'hC, rd);
    chk(rd, adcpc_pkg::READ_ZERO);
    end_sim();
  end
endmodule
`default_nettype wire
